// file: logic/sbst_tap.sv
//Function
//- full standard test port state and instructions
//- sample inputs rising, change outputs falling
//- unconnected tms and tdi read high
//- shift in at msb, out lsb
//- tdo driven only while shifting
//- five tms-high edges reach reset state
//- power-up reset of test controller
//- instruction alone picks one data register
//- three-bit ir, loads identification on reset
//- capture-ir loads 01 in low bits
//- new instruction applied only at update-ir
//- one-bit bypass cleared at capture
//- boundary chain covers all pins
//- boundary instructions capture ring, then shift
//- identification captures hardwired 32-bit code
//- scan-floated instruction floats read outputs
//- sample snapshot, shift out while preloading
//- update-dr moves shift cells to latch
//- external test drives latched values out
//- cell 108 high enables read outputs
//- tristate latch resets low
//- identification 001, bypass 111
//- extest 000, scan-floated 010, sample 100
//- id word revision, type, maker, one
module sbst_tap
   import sbst_pkg::*;
(
   input  wire logic              MCLK,
   input  wire logic              RST,
   input  wire logic              TCK,
   input  wire logic              TMS,
   input  wire logic              TDI,
   output logic                   TDO,
   output logic                   TDO_OE,
   output logic                   Q_OE,
   output logic                   EXTEST_ON,
   input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic              S_AXI_AWVALID,
   output logic                   S_AXI_AWREADY,
   input  wire logic [31:0]       S_AXI_WDATA,
   input  wire logic [3:0]        S_AXI_WSTRB,
   input  wire logic              S_AXI_WVALID,
   output logic                   S_AXI_WREADY,
   output logic [1:0]             S_AXI_BRESP,
   output logic                   S_AXI_BVALID,
   input  wire logic              S_AXI_BREADY,
   input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic              S_AXI_ARVALID,
   output logic                   S_AXI_ARREADY,
   output logic [31:0]            S_AXI_RDATA,
   output logic [1:0]             S_AXI_RRESP,
   output logic                   S_AXI_RVALID,
   input  wire logic              S_AXI_RREADY
);

   // ****************************************************************
   // state of the whole block
   // ****************************************************************
   typedef struct packed {
      logic              tck_m;
      logic              tck_s;
      logic              tck_d;
      logic              tms_m;
      logic              tms_s;
      logic              tdi_m;
      logic              tdi_s;
      sbst_tap_t         tap;
      logic [IR_W-1:0]   ir;
      logic [IR_W-1:0]   ir_sh;
      logic              byp;
      logic [ID_W-1:0]   id_sh;
      logic [BSR_W-1:0]  bsr_sh;
      logic [BSR_W-1:0]  bsr_lat;
      logic              tdo;
      logic              tdo_oe;
      logic              q_oe;
      logic              ext;
      logic [RING_W-1:0] ring_in;
      logic              aw_full;
      logic              w_full;
      logic [ADDR_W-1:0] awaddr;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              awrdy;
      logic              wrdy;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arrdy;
      logic              rvalid;
      logic [31:0]       rdata;
      logic [1:0]        rresp;
   } sbst_state_t;

   sbst_state_t s_reg;
   sbst_state_t s_next;
   logic        tck_rise;
   logic        tck_fall;
   logic        shifting;
   logic        sel_bsr;
   logic        sel_id;

   // ****************************************************************
   // helper functions
   // ****************************************************************

   // standard sixteen-state walk, one step per tck rise
   function automatic sbst_tap_t tap_step(input sbst_tap_t st, input logic tms);
      case (st)
         TAP_RESET:    tap_step = tms ? TAP_RESET    : TAP_IDLE;
         TAP_IDLE:     tap_step = tms ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_DR:   tap_step = tms ? TAP_SEL_IR   : TAP_CAP_DR;
         TAP_CAP_DR:   tap_step = tms ? TAP_EX1_DR   : TAP_SHIFT_DR;
         TAP_SHIFT_DR: tap_step = tms ? TAP_EX1_DR   : TAP_SHIFT_DR;
         TAP_EX1_DR:   tap_step = tms ? TAP_UPD_DR   : TAP_PAUSE_DR;
         TAP_PAUSE_DR: tap_step = tms ? TAP_EX2_DR   : TAP_PAUSE_DR;
         TAP_EX2_DR:   tap_step = tms ? TAP_UPD_DR   : TAP_SHIFT_DR;
         TAP_UPD_DR:   tap_step = tms ? TAP_SEL_DR   : TAP_IDLE;
         TAP_SEL_IR:   tap_step = tms ? TAP_RESET    : TAP_CAP_IR;
         TAP_CAP_IR:   tap_step = tms ? TAP_EX1_IR   : TAP_SHIFT_IR;
         TAP_SHIFT_IR: tap_step = tms ? TAP_EX1_IR   : TAP_SHIFT_IR;
         TAP_EX1_IR:   tap_step = tms ? TAP_UPD_IR   : TAP_PAUSE_IR;
         TAP_PAUSE_IR: tap_step = tms ? TAP_EX2_IR   : TAP_PAUSE_IR;
         TAP_EX2_IR:   tap_step = tms ? TAP_UPD_IR   : TAP_SHIFT_IR;
         TAP_UPD_IR:   tap_step = tms ? TAP_SEL_DR   : TAP_IDLE;
         default:      tap_step = TAP_RESET;
      endcase
   endfunction

   // boundary chain owns the path under these three codes
   function automatic logic is_boundary(input logic [IR_W-1:0] ins);
      is_boundary = (ins == INS_EXTEST) || (ins == INS_SAMPLE) || (ins == INS_SAMPLEZ);
   endfunction

   // one 32-bit word out of a 128-bit ring image
   function automatic logic [31:0] ring_word(input logic [RING_W-1:0] v, input logic [1:0] idx);
      ring_word = v[{idx, 5'h00} +: 32];
   endfunction

   // byte-lane merge for bus writes
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      merge = r;
   endfunction

   // value every field takes at power-up
   function automatic sbst_state_t reset_state();
      sbst_state_t r;
      r         = '0;
      r.tap     = TAP_RESET;
      r.ir      = INS_IDCODE;
      r.tms_m   = 1'b1;
      r.tms_s   = 1'b1;
      r.tdi_m   = 1'b1;
      r.tdi_s   = 1'b1;
      r.q_oe    = 1'b1;
      r.awrdy   = 1'b1;
      r.wrdy    = 1'b1;
      r.arrdy   = 1'b1;
      reset_state = r;
   endfunction

   // ****************************************************************
   // tck edge finding and path selection
   // ****************************************************************

   // edges come from the second and third stages, never the first
   assign tck_rise = s_reg.tck_s & ~s_reg.tck_d;
   assign tck_fall = ~s_reg.tck_s & s_reg.tck_d;
   assign shifting = (s_reg.tap == TAP_SHIFT_DR) || (s_reg.tap == TAP_SHIFT_IR);
   // reserved codes fall back to bypass so the chain never breaks
   assign sel_bsr  = is_boundary(s_reg.ir);
   assign sel_id   = (s_reg.ir == INS_IDCODE);

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   always_comb begin
      s_next = s_reg;

      // two-flop synchronisers; pads idle high so a floating pin rests in reset
      s_next.tck_m = TCK;
      s_next.tck_s = s_reg.tck_m;
      s_next.tck_d = s_reg.tck_s;
      s_next.tms_m = TMS;
      s_next.tms_s = s_reg.tms_m;
      s_next.tdi_m = TDI;
      s_next.tdi_s = s_reg.tdi_m;

      // rising tck: step the controller, capture and shift
      if (tck_rise) begin
         s_next.tap = tap_step(s_reg.tap, s_reg.tms_s);
         case (s_reg.tap)
            TAP_CAP_IR: begin
               s_next.ir_sh = IR_CAPTURE;
            end
            TAP_SHIFT_IR: begin
               s_next.ir_sh = {s_reg.tdi_s, s_reg.ir_sh[IR_W-1:1]};
            end
            TAP_CAP_DR: begin
               if (sel_bsr) begin
                  s_next.bsr_sh = s_reg.ring_in[BSR_W-1:0];
               end else if (sel_id) begin
                  s_next.id_sh = IDCODE_VALUE;
               end else begin
                  s_next.byp = 1'b0;
               end
            end
            TAP_SHIFT_DR: begin
               if (sel_bsr) begin
                  s_next.bsr_sh = {s_reg.tdi_s, s_reg.bsr_sh[BSR_W-1:1]};
               end else if (sel_id) begin
                  s_next.id_sh = {s_reg.tdi_s, s_reg.id_sh[ID_W-1:1]};
               end else begin
                  s_next.byp = s_reg.tdi_s;
               end
            end
            default: begin
            end
         endcase
      end

      // falling tck: drive tdo and apply updates
      if (tck_fall) begin
         s_next.tdo_oe = shifting;
         if (s_reg.tap == TAP_SHIFT_IR) begin
            s_next.tdo = s_reg.ir_sh[0];
         end else if (sel_bsr) begin
            s_next.tdo = s_reg.bsr_sh[0];
         end else if (sel_id) begin
            s_next.tdo = s_reg.id_sh[0];
         end else begin
            s_next.tdo = s_reg.byp;
         end
         if (s_reg.tap == TAP_UPD_IR) begin
            s_next.ir = s_reg.ir_sh;
         end
         if ((s_reg.tap == TAP_UPD_DR) && sel_bsr) begin
            s_next.bsr_lat = s_reg.bsr_sh;
         end
      end

      // reset state holds identification and a low tristate cell
      if (s_reg.tap == TAP_RESET) begin
         s_next.ir                = INS_IDCODE;
         s_next.bsr_lat[TRI_CELL] = 1'b0;
      end

      // output bus control follows the instruction now in force
      s_next.ext = (s_next.ir == INS_EXTEST);
      if (s_next.ir == INS_EXTEST) begin
         s_next.q_oe = s_next.bsr_lat[TRI_CELL];
      end else if (s_next.ir == INS_SAMPLEZ) begin
         s_next.q_oe = 1'b0;
      end else begin
         s_next.q_oe = 1'b1;
      end

      // bus write: address and data taken in either order
      if (S_AXI_AWVALID && s_reg.awrdy) begin
         s_next.aw_full = 1'b1;
         s_next.awaddr  = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && s_reg.wrdy) begin
         s_next.w_full = 1'b1;
         s_next.wdata  = S_AXI_WDATA;
         s_next.wstrb  = S_AXI_WSTRB;
      end
      if (s_reg.bvalid && S_AXI_BREADY) begin
         s_next.bvalid = 1'b0;
      end
      if (s_reg.aw_full && s_reg.w_full && !s_reg.bvalid) begin
         s_next.aw_full = 1'b0;
         s_next.w_full  = 1'b0;
         s_next.bvalid  = 1'b1;
         if ((s_reg.awaddr & OFS_GROUP) == OFS_RING_IN) begin
            s_next.ring_in[{s_reg.awaddr[3:2], 5'h00} +: 32] =
               merge(ring_word(s_reg.ring_in, s_reg.awaddr[3:2]), s_reg.wdata, s_reg.wstrb);
            s_next.bresp = RESP_OKAY;
         end else begin
            s_next.bresp = RESP_SLVERR;
         end
      end
      s_next.awrdy = !s_next.aw_full;
      s_next.wrdy  = !s_next.w_full;

      // bus read: one answer at a time, unmapped reads give slverr and zero
      if (s_reg.rvalid && S_AXI_RREADY) begin
         s_next.rvalid = 1'b0;
      end
      if (S_AXI_ARVALID && s_reg.arrdy) begin
         s_next.rvalid = 1'b1;
         s_next.rresp  = RESP_OKAY;
         s_next.rdata  = 32'h00000000;
         if (S_AXI_ARADDR == OFS_STATUS) begin
            s_next.rdata[ST_TAP_LSB +: 16]  = s_reg.tap;
            s_next.rdata[ST_IR_LSB +: IR_W] = s_reg.ir;
            s_next.rdata[ST_QOE_BIT]        = s_reg.q_oe;
            s_next.rdata[ST_EXT_BIT]        = s_reg.ext;
            s_next.rdata[ST_TDOE_BIT]       = s_reg.tdo_oe;
         end else if ((S_AXI_ARADDR & OFS_GROUP) == OFS_RING_IN) begin
            s_next.rdata = ring_word({{RING_PAD{1'b0}}, s_reg.ring_in[BSR_W-1:0]}, S_AXI_ARADDR[3:2]);
         end else if ((S_AXI_ARADDR & OFS_GROUP) == OFS_PRELOAD) begin
            s_next.rdata = ring_word({{RING_PAD{1'b0}}, s_reg.bsr_lat}, S_AXI_ARADDR[3:2]);
         end else begin
            s_next.rresp = RESP_SLVERR;
         end
      end
      s_next.arrdy = !s_next.rvalid;

      // synchronous power-up reset of everything
      if (RST) begin
         s_next = reset_state();
      end
   end

   // ****************************************************************
   // state register and outputs
   // ****************************************************************
   always_ff @(posedge MCLK) begin
      s_reg <= s_next;
   end

   assign TDO           = s_reg.tdo;
   assign TDO_OE        = s_reg.tdo_oe;
   assign Q_OE          = s_reg.q_oe;
   assign EXTEST_ON     = s_reg.ext;
   assign S_AXI_AWREADY = s_reg.awrdy;
   assign S_AXI_WREADY  = s_reg.wrdy;
   assign S_AXI_BVALID  = s_reg.bvalid;
   assign S_AXI_BRESP   = s_reg.bresp;
   assign S_AXI_ARREADY = s_reg.arrdy;
   assign S_AXI_RVALID  = s_reg.rvalid;
   assign S_AXI_RDATA   = s_reg.rdata;
   assign S_AXI_RRESP   = s_reg.rresp;

   // ****************************************************************
   // checks
   // ****************************************************************

   // helper: consecutive tck rises with tms high, saturating
   logic [2:0] hi_cnt;
   logic       in_reset;
   assign in_reset = (s_reg.tap == TAP_RESET);
   always_ff @(posedge MCLK) begin
      if (RST) begin
         hi_cnt <= 3'h0;
      end else if (tck_rise) begin
         hi_cnt <= !s_reg.tms_s ? 3'h0 : (hi_cnt == 3'(RESET_TMS_EDGES)) ? hi_cnt : hi_cnt + 3'h1;
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (RST);

   chk_tms_reset_five: assert property (hi_cnt == 3'(RESET_TMS_EDGES) |-> s_reg.tap == TAP_RESET)
      else $error("five tms-high edges did not reach reset");
   chk_tdo_enable: assert property (tck_fall |=> TDO_OE == $past(shifting))
      else $error("tdo enable wrong for controller state");
   chk_tdo_on_fall: assert property (!tck_fall |=> $stable(TDO) && $stable(TDO_OE))
      else $error("tdo changed away from a falling tck");
   chk_tap_on_rise: assert property (!tck_rise |=> $stable(s_reg.tap))
      else $error("controller moved away from a rising tck");
   chk_capir_pattern: assert property (tck_rise && s_reg.tap == TAP_CAP_IR |=> s_reg.ir_sh[1:0] == 2'b01)
      else $error("capture-ir pattern not 01");
   chk_ir_update_only: assert property ($changed(s_reg.ir) |-> $past(s_reg.tap) inside {TAP_UPD_IR, TAP_RESET})
      else $error("instruction changed outside update-ir");
   chk_ir_reset_id: assert property ($past(in_reset) |-> s_reg.ir == INS_IDCODE && !s_reg.bsr_lat[TRI_CELL])
      else $error("reset did not load identification and low tristate cell");
   chk_bypass_clear: assert property (tck_rise && s_reg.tap == TAP_CAP_DR && s_reg.ir == INS_BYPASS |=> !s_reg.byp)
      else $error("bypass not cleared at capture");
   chk_id_capture: assert property (tck_rise && s_reg.tap == TAP_CAP_DR && sel_id |=> s_reg.id_sh == IDCODE_VALUE)
      else $error("identification code not captured");
   chk_samplez_float: assert property (s_reg.ir == INS_SAMPLEZ |-> !Q_OE && !EXTEST_ON)
      else $error("read outputs not floated under scan-floated");
   chk_extest_tristate: assert property (s_reg.ir == INS_EXTEST |-> Q_OE == s_reg.bsr_lat[TRI_CELL])
      else $error("output enable does not follow cell 108");
   chk_scan_msb_in: assert property (tck_rise && s_reg.tap == TAP_SHIFT_DR && sel_bsr
                                     |=> s_reg.bsr_sh == {$past(s_reg.tdi_s), $past(s_reg.bsr_sh[BSR_W-1:1])})
      else $error("boundary shift not msb in, lsb out");

   cov_id_shift: cover property (tck_rise && s_reg.tap == TAP_SHIFT_DR && sel_id);
   cov_extest_drive: cover property (EXTEST_ON && Q_OE);
   cov_samplez_set: cover property (tck_fall && s_reg.tap == TAP_UPD_IR && s_reg.ir_sh == INS_SAMPLEZ);
   cov_tms_reset: cover property ($rose(in_reset));

endmodule

// file: inc/sbst_pkg.sv
package sbst_pkg;

   // ****************************************************************
   // scan register geometry
   // ****************************************************************
   localparam int unsigned IR_W      = 3;
   localparam int unsigned ID_W      = 32;
   localparam int unsigned BSR_W     = 109;
   localparam int unsigned TRI_CELL  = 108;
   localparam int unsigned RING_W    = 128;      // four bus words hold the ring image
   localparam int unsigned RING_PAD  = RING_W - BSR_W;
   localparam int unsigned RESET_TMS_EDGES = 5;  // tms high edges that always reach reset

   // ****************************************************************
   // instruction encodings
   // ****************************************************************
   localparam logic [2:0] INS_EXTEST  = 3'h0;
   localparam logic [2:0] INS_IDCODE  = 3'h1;
   localparam logic [2:0] INS_SAMPLEZ = 3'h2;
   localparam logic [2:0] INS_SAMPLE  = 3'h4;
   localparam logic [2:0] INS_BYPASS  = 3'h7;
   localparam logic [2:0] IR_CAPTURE  = 3'h1;    // low two bits 01 for path fault isolation

   // ****************************************************************
   // identification word
   // ****************************************************************
   localparam logic [2:0]  ID_REVISION = 3'h0;      // value is arbitrary
   localparam logic [16:0] ID_DEVICE   = 17'h0A5A5; // value is arbitrary
   localparam logic [10:0] ID_MAKER    = 11'h2AB;   // value is arbitrary
   localparam logic        ID_PRESENT  = 1'b1;
   localparam logic [31:0] IDCODE_VALUE = {ID_REVISION, ID_DEVICE, ID_MAKER, ID_PRESENT};

   // ****************************************************************
   // register map and bus answers
   // ****************************************************************
   localparam int unsigned ADDR_W       = 8;
   localparam logic [7:0] OFS_STATUS    = 8'h00;
   localparam logic [7:0] OFS_RING_IN   = 8'h10;
   localparam logic [7:0] OFS_PRELOAD   = 8'h20;
   localparam logic [7:0] OFS_GROUP     = 8'hF0;
   localparam logic [1:0] RESP_OKAY     = 2'h0;
   localparam logic [1:0] RESP_SLVERR   = 2'h2;
   localparam int unsigned ST_TAP_LSB   = 0;
   localparam int unsigned ST_IR_LSB    = 16;
   localparam int unsigned ST_QOE_BIT   = 19;
   localparam int unsigned ST_EXT_BIT   = 20;
   localparam int unsigned ST_TDOE_BIT  = 21;

   // ****************************************************************
   // test controller states, one-hot
   // ****************************************************************
   typedef enum logic [15:0] {
      TAP_RESET    = 16'h0001,
      TAP_IDLE     = 16'h0002,
      TAP_SEL_DR   = 16'h0004,
      TAP_CAP_DR   = 16'h0008,
      TAP_SHIFT_DR = 16'h0010,
      TAP_EX1_DR   = 16'h0020,
      TAP_PAUSE_DR = 16'h0040,
      TAP_EX2_DR   = 16'h0080,
      TAP_UPD_DR   = 16'h0100,
      TAP_SEL_IR   = 16'h0200,
      TAP_CAP_IR   = 16'h0400,
      TAP_SHIFT_IR = 16'h0800,
      TAP_EX1_IR   = 16'h1000,
      TAP_PAUSE_IR = 16'h2000,
      TAP_EX2_IR   = 16'h4000,
      TAP_UPD_IR   = 16'h8000
   } sbst_tap_t;

endpackage

// file: bench/sbst_jtag_host.sv
// ************
// board test controller model
// ************
module sbst_jtag_host (
   input  wire logic mclk,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   timeunit 1ns;
   timeprecision 1ps;

   // tck rests low between frames, tms high keeps the port quiet
   initial begin
      tck = 1'b0;
      tms = 1'b1;
      tdi = 1'b1;
   end

   // one 80 ns tck period; tms and tdi set a half period before the rise
   // a released tdo reads unknown so a missing enable never matches
   task automatic step(input logic m, input logic d, output logic o);
      tms <= m;
      tdi <= d;
      repeat (10) @(posedge mclk);
      o = tdo_oe ? tdo : 1'bx;
      tck <= 1'b1;
      repeat (10) @(posedge mclk);
      tck <= 1'b0;
   endtask
endmodule

// file: bench/testbench.sv
// ************
// bench top
// ************
module testbench
   import sbst_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic         mclk = 1'b0, rst = 1'b1, tck, tms, tdi, tdo, tdo_oe, q_oe, ext_on, awr, wrdy, arr, bv, rv, b;
   logic         awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
   logic [7:0]   awaddr = 8'h00, araddr = 8'h00;
   logic [31:0]  wdata = 32'h0, rdata, rd_w;
   logic [3:0]   ws = 4'hF;
   logic [1:0]   bresp, rresp, rsp;
   logic [127:0] got, ring, pat;
   int           bad_count = 0, total_checks = 0, cyc = 0;
   integer       seed = 32'hC2F755F0;

   // 250 MHz system clock
   always #2 mclk = ~mclk;

   sbst_tap u_dut (.MCLK(mclk), .RST(rst), .TCK(tck), .TMS(tms), .TDI(tdi), .TDO(tdo), .TDO_OE(tdo_oe),
      .Q_OE(q_oe), .EXTEST_ON(ext_on), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr),
      .S_AXI_WDATA(wdata), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bv), .S_AXI_BREADY(brdy), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv),
      .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy));
   sbst_jtag_host u_host (.mclk(mclk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

   task automatic chk(input logic [127:0] g, input logic [127:0] e);
      total_checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // status word built from the package field positions, tdo enable expected low
   function automatic logic [31:0] st_word(input logic [15:0] t, input logic [2:0] i, input logic q,
                                           input logic e);
      st_word = 32'h00000000;
      st_word[ST_TAP_LSB +: 16] = t;
      st_word[ST_IR_LSB +: 3] = i;
      st_word[ST_QOE_BIT] = q;
      st_word[ST_EXT_BIT] = e;
   endfunction

   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // the whole run needs about 4800 cycles; a hang is cut well after that
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         end_sim();
      end
   end

   // one bus cycle; readies sampled mid-cycle so nothing races the edge
   task automatic axi(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [1:0] r,
                      output logic [31:0] q);
      logic done, ta, tw, tr;
      done = 1'b0;
      @(posedge mclk);
      awaddr <= a;
      araddr <= a;
      wdata <= d;
      awv <= w;
      wv <= w;
      brdy <= w;
      arv <= !w;
      rrdy <= !w;
      while (!done) begin
         @(negedge mclk);
         {ta, tw, tr} = {awr, wrdy, arr};
         done = w ? bv : rv;
         r = w ? bresp : rresp;
         q = rdata;
         @(posedge mclk);
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (tr) arv <= 1'b0;
         if (done) {brdy, rrdy} <= 2'b00;
      end
   endtask

   // from idle into shift, n bits lsb first, through update back to idle
   task automatic scan(input logic ir, input int n, input logic [127:0] din, output logic [127:0] dout);
      logic o;
      dout = '0;
      u_host.step(1'b1, 1'b0, o);
      if (ir) u_host.step(1'b1, 1'b0, o);
      u_host.step(1'b0, 1'b0, o);
      u_host.step(1'b0, 1'b0, o);
      for (int i = 0; i < n; i++) begin
         u_host.step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      u_host.step(1'b1, 1'b0, o);
      u_host.step(1'b0, 1'b0, o);
   endtask

   // five tms-high rises from any state, then into idle
   task automatic tap_rst();
      repeat (5) u_host.step(1'b1, 1'b0, b);
      u_host.step(1'b0, 1'b0, b);
   endtask

   initial begin
      repeat (8) @(posedge mclk);
      rst <= 1'b0;
      repeat (4) @(posedge mclk);
      chk(tdo_oe, 1'b0);
      chk({ext_on, q_oe}, 2'b01);
      axi(1'b0, OFS_STATUS, 32'h0, rsp, rd_w);
      chk(rd_w, st_word(TAP_RESET, INS_IDCODE, 1'b1, 1'b0));
      axi(1'b0, OFS_PRELOAD + 8'hC, 32'h0, rsp, rd_w);
      chk(rd_w[TRI_CELL - 96], 1'b0);
      u_host.step(1'b0, 1'b0, b);
      pat = {$random(seed), $random(seed), $random(seed), $random(seed)};
      scan(1'b0, ID_W, pat, got);
      chk(got[31:0], IDCODE_VALUE);
      chk(tdo_oe, 1'b0);
      scan(1'b1, IR_W, {125'h0, INS_BYPASS}, got);
      chk(got[1:0], 2'b01);
      scan(1'b0, 16, pat, got);
      chk(got[15:0], {pat[14:0], 1'b0});
      // abandon a scan mid-shift; the tms reset must restore identification
      u_host.step(1'b1, 1'b0, b);
      repeat (3) u_host.step(1'b0, 1'b0, b);
      tap_rst();
      axi(1'b0, OFS_STATUS, 32'h0, rsp, rd_w);
      chk(rd_w, st_word(TAP_IDLE, INS_IDCODE, 1'b1, 1'b0));
      for (int k = 0; k < 4; k++) begin
         ring[32*k+:32] = $random(seed);
         axi(1'b1, OFS_RING_IN + 8'(4 * k), ring[32*k+:32], rsp, rd_w);
         chk(rsp, RESP_OKAY);
      end
      ws <= 4'h1;
      axi(1'b1, OFS_RING_IN, 32'hFFFFFFFF, rsp, rd_w);
      ws <= 4'hF;
      ring[7:0] = 8'hFF;
      pat = {$random(seed), $random(seed), $random(seed), $random(seed)};
      pat[127:109] = '0;
      pat[TRI_CELL] = 1'b1;
      // the host loads only the five defined codes, never a reserved one
      scan(1'b1, IR_W, {125'h0, INS_SAMPLE}, got);
      scan(1'b0, BSR_W, pat, got);
      chk(got[108:0], ring[108:0]);
      for (int k = 0; k < 4; k++) begin
         axi(1'b0, OFS_PRELOAD + 8'(4 * k), 32'h0, rsp, rd_w);
         chk(rd_w, pat[32*k+:32]);
      end
      scan(1'b1, IR_W, {125'h0, INS_EXTEST}, got);
      chk({ext_on, q_oe}, 2'b11);
      scan(1'b1, IR_W, {125'h0, INS_SAMPLEZ}, got);
      chk({ext_on, q_oe}, 2'b00);
      tap_rst();
      scan(1'b1, IR_W, {125'h0, INS_EXTEST}, got);
      chk({ext_on, q_oe}, 2'b10);
      axi(1'b0, 8'h40, 32'h0, rsp, rd_w);
      chk({rsp, rd_w}, {RESP_SLVERR, 32'h0});
      axi(1'b1, OFS_STATUS, 32'h0, rsp, rd_w);
      chk(rsp, RESP_SLVERR);
      end_sim();
   end
endmodule
